//--- verilog/dad_pkg.sv
// Notes on behaviour
// - ALU first operand is always accumulator.
// - Second operand: product path or scaling shifter.
// - ALU result written back to accumulator.
// - Accumulator stored as high and low halves.
// - Store path shifts; accumulator left unchanged.
// - Branch on accumulator value or single bit.
// - Branch target may come from accumulator.
// - Normalize fixed-point value in accumulator.
// - Test selected bit of data word.
// - Scaler takes 16 bits, gives 32 bits.
// - Scaler shifts left 0 through 16.
// - Scaler low vacated bits filled with zeros.
// - Scaler upper bits sign-extend when mode set.
// - 16x16 signed/unsigned multiply, one cycle.
// - One multiplier operand held in register.
// - Each product captured in 32-bit register.
// - Multiply-accumulate takes both buses same cycle.
// - Product output shifter has four modes.
// - Most ALU operations take one cycle.
package dad_pkg;

  // Datapath widths
  localparam int DATA_W  = 16;
  localparam int ACC_W   = 32;
  localparam int SHAMT_W = 5;
  localparam int BITSEL_W = 4;

  // Reset values of the datapath registers
  localparam logic [31:0] ACC_RST     = 32'h0000_0000;
  localparam logic [31:0] PRODUCT_RST = 32'h0000_0000;
  localparam logic [15:0] OPREG_RST   = 16'h0000;

  // Largest scaling shift
  localparam logic [4:0] SHAMT_MAX = 5'h10;

  // ALU operations from the decoder
  typedef enum logic [3:0] {
    DAD_OP_NOP  = 4'b0000,
    DAD_OP_ADD  = 4'b0001,
    DAD_OP_SUB  = 4'b0010,
    DAD_OP_AND  = 4'b0011,
    DAD_OP_OR   = 4'b0100,
    DAD_OP_XOR  = 4'b0101,
    DAD_OP_LOAD = 4'b0110,
    DAD_OP_NORM = 4'b0111,
    DAD_OP_MAC  = 4'b1000
  } dad_aluop_t;

  // Product shift modes
  typedef enum logic [1:0] {
    DAD_PM_NONE  = 2'b00,
    DAD_PM_LEFT1 = 2'b01,
    DAD_PM_LEFT4 = 2'b10,
    DAD_PM_RIGHT6 = 2'b11
  } dad_pmode_t;

  // Product shift amounts per mode
  localparam int PM_LEFT1_AMT  = 1;
  localparam int PM_LEFT4_AMT  = 4;
  localparam int PM_RIGHT6_AMT = 6;

  // Branch conditions
  typedef enum logic [2:0] {
    DAD_BC_ALWAYS = 3'b000,
    DAD_BC_EQ     = 3'b001,
    DAD_BC_NE     = 3'b010,
    DAD_BC_LT     = 3'b011,
    DAD_BC_GT     = 3'b100,
    DAD_BC_BIT    = 3'b101,
    DAD_BC_NEVER  = 3'b110
  } dad_bcond_t;

endpackage

//--- verilog/dad_scaler.sv
`timescale 1ns/1ps
`default_nettype none
module dad_scaler (
  input  wire logic [15:0] dataIn,   // Operand from the data bus
  input  wire logic [4:0]  shAmt,    // Left shift 0..16
  input  wire logic        signExt,  // Sign-extension mode
  output logic      [31:0] dataOut   // Aligned value to the ALU
);
  // Widen first so the shift never loses bits
  wire [31:0] widened;
  wire [4:0]  clampAmt;

  assign widened  = signExt ? {{16{dataIn[15]}}, dataIn} : {16'h0000, dataIn};
  // Amounts above 16 are clamped; decoder should never issue them
  assign clampAmt = (shAmt > dad_pkg::SHAMT_MAX) ? dad_pkg::SHAMT_MAX : shAmt;
  assign dataOut  = widened << clampAmt;
endmodule
`default_nettype wire

//--- verilog/dad_multiplier.sv
`timescale 1ns/1ps
`default_nettype none
module dad_multiplier (
  input  wire logic [15:0] opA,       // Held operand
  input  wire logic [15:0] opB,       // Operand from a bus
  input  wire logic        isSigned,  // Signed when high
  output logic      [31:0] product    // Full product, combinational
);
  // Extend to 17 bits so one signed multiplier covers both modes
  wire signed [16:0] extA;
  wire signed [16:0] extB;
  wire signed [33:0] full;

  assign extA    = {isSigned & opA[15], opA};
  assign extB    = {isSigned & opB[15], opB};
  assign full    = extA * extB;
  assign product = full[31:0];
endmodule
`default_nettype wire

//--- verilog/dad_arith_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module dad_arith_datapath (
  input  wire logic        clk_sys,      // Machine clock
  input  wire logic        rst_n,        // Async reset, active low
  // Decoder controls
  input  wire logic [3:0]  aluOp,        // ALU operation
  input  wire logic        selProduct,   // Second operand from product path
  input  wire logic [4:0]  shiftAmt,     // Scaling shift amount
  input  wire logic        sign_ext_mode_bit, // Sign-extension mode status
  input  wire logic [1:0]  prodMode,     // Product shift mode
  input  wire logic        mulSigned,    // Signed multiply
  input  wire logic        loadOpReg,    // Load held multiplier operand
  input  wire logic        mulStart,     // Multiply into product register
  input  wire logic        mulFromProg,  // Second factor from program bus
  input  wire logic        storeHigh,    // Store high accumulator half
  input  wire logic        storeLow,     // Store low accumulator half
  input  wire logic [2:0]  storeShift,   // Output shift on stores
  input  wire logic [2:0]  branchCond,   // Branch condition
  input  wire logic        branchReq,    // Evaluate branch this cycle
  input  wire logic        branchAcc,    // Target from accumulator
  input  wire logic [15:0] branchImm,    // Immediate branch target
  input  wire logic        bitTest,      // Capture bit test result
  input  wire logic [3:0]  bitSel,       // Bit index to test
  // Buses
  input  wire logic [15:0] dataBusIn,    // Data bus read value
  input  wire logic [15:0] progBusIn,    // Program bus read value
  output logic      [15:0] dataBusOut,   // Store data
  output logic             dataBusWr,    // Store strobe
  // Results
  output logic      [31:0] accOut,       // Accumulator contents
  output logic      [31:0] productOut,   // Product register contents
  output logic      [15:0] mult_operand_reg, // Held multiplier operand
  output logic             branchTaken,  // Branch taken pulse
  output logic      [15:0] branchTarget, // Branch destination
  output logic             testBit,      // Bit test result flag
  output logic             carry,        // Carry from last add/sub
  output logic             overflow,     // Signed overflow
  output logic             normDone      // Accumulator already normalized
);

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [31:0] acc;           // Accumulator
  logic [31:0] product_reg;   // Product register
  logic [15:0] opReg;         // Held multiplier factor
  logic        carryFlag;     // Carry status
  logic        ovFlag;        // Overflow status
  logic        tcFlag;        // Test/control flag
  logic [15:0] storeData;     // Registered store word
  logic        storeStrobe;   // Registered store strobe
  logic        brTaken;       // Registered branch decision
  logic [15:0] brTarget;      // Registered branch target

  //////////////////////////////////////////////////////////////////////////////
  // Input scaling shifter
  wire [31:0] scaled;

  dad_scaler uScaler (
    .dataIn  (dataBusIn),
    .shAmt   (shiftAmt),
    .signExt (sign_ext_mode_bit),
    .dataOut (scaled)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Multiplier
  wire [15:0] mulFactor;
  wire [31:0] mulResult;

  // Second factor comes over program bus for multiply-accumulate
  assign mulFactor = mulFromProg ? progBusIn : dataBusIn;

  dad_multiplier uMult (
    .opA      (opReg),
    .opB      (mulFactor),
    .isSigned (mulSigned),
    .product  (mulResult)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Product output shifter
  wire [31:0] prodShifted;

  // Right shift is arithmetic so fractional products keep their sign
  assign prodShifted =
    (prodMode == dad_pkg::DAD_PM_LEFT1) ? (product_reg << dad_pkg::PM_LEFT1_AMT) :
    (prodMode == dad_pkg::DAD_PM_LEFT4) ? (product_reg << dad_pkg::PM_LEFT4_AMT) :
    (prodMode == dad_pkg::DAD_PM_RIGHT6) ?
      32'($signed(product_reg) >>> dad_pkg::PM_RIGHT6_AMT) :
    product_reg;

  //////////////////////////////////////////////////////////////////////////////
  // ALU
  wire [31:0] operandA;
  wire [31:0] operandB;
  wire [32:0] sumAdd;
  wire [32:0] sumSub;
  wire        ovAdd;
  wire        ovSub;
  wire [31:0] normVal;
  wire        isNorm;

  assign operandA = acc;
  assign operandB = selProduct ? prodShifted : scaled;
  assign sumAdd   = {1'b0, operandA} + {1'b0, operandB};
  assign sumSub   = {1'b0, operandA} - {1'b0, operandB};
  assign ovAdd    = (operandA[31] == operandB[31]) && (sumAdd[31] != operandA[31]);
  assign ovSub    = (operandA[31] != operandB[31]) && (sumSub[31] != operandA[31]);
  // Normalized when the two top bits differ, or the value is zero
  assign isNorm   = (acc[31] != acc[30]) || (acc == 32'h0000_0000);
  assign normVal  = isNorm ? acc : {acc[30:0], 1'b0};

  wire [31:0] aluResult;
  wire        aluWrites;

  assign aluResult =
    (aluOp == dad_pkg::DAD_OP_ADD)  ? sumAdd[31:0] :
    (aluOp == dad_pkg::DAD_OP_MAC)  ? sumAdd[31:0] :
    (aluOp == dad_pkg::DAD_OP_SUB)  ? sumSub[31:0] :
    (aluOp == dad_pkg::DAD_OP_AND)  ? (operandA & operandB) :
    (aluOp == dad_pkg::DAD_OP_OR)   ? (operandA | operandB) :
    (aluOp == dad_pkg::DAD_OP_XOR)  ? (operandA ^ operandB) :
    (aluOp == dad_pkg::DAD_OP_LOAD) ? operandB :
    (aluOp == dad_pkg::DAD_OP_NORM) ? normVal :
    acc;
  // Every op except NOP rewrites the accumulator
  assign aluWrites = (aluOp != dad_pkg::DAD_OP_NOP);

  wire isAddLike;
  wire isSubOp;
  assign isAddLike = (aluOp == dad_pkg::DAD_OP_ADD) || (aluOp == dad_pkg::DAD_OP_MAC);
  assign isSubOp   = (aluOp == dad_pkg::DAD_OP_SUB);

  //////////////////////////////////////////////////////////////////////////////
  // Accumulator and status: one cycle per operation
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc       <= dad_pkg::ACC_RST;
      carryFlag <= 1'b0;
      ovFlag    <= 1'b0;
    end else begin
      if (aluWrites) begin
        acc <= aluResult;
      end
      if (isAddLike) begin
        carryFlag <= sumAdd[32];
        ovFlag    <= ovAdd;
      end else if (isSubOp) begin
        carryFlag <= ~sumSub[32];
        ovFlag    <= ovSub;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Multiplier registers
  // MAC reads old product before the new one lands, pipelining the sum
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opReg       <= dad_pkg::OPREG_RST;
      product_reg <= dad_pkg::PRODUCT_RST;
    end else begin
      if (loadOpReg) begin
        opReg <= dataBusIn;
      end
      if (mulStart) begin
        product_reg <= mulResult;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Accumulator stores through output shifter; accumulator untouched
  wire [31:0] accStoreShifted;
  wire [15:0] storeWord;
  wire        storeReq;

  assign accStoreShifted = acc << storeShift;
  // High half wins if both are requested in one cycle
  assign storeWord = storeHigh ? accStoreShifted[31:16] : accStoreShifted[15:0];
  assign storeReq  = storeHigh | storeLow;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      storeData   <= 16'h0000;
      storeStrobe <= 1'b0;
    end else begin
      storeStrobe <= storeReq;
      if (storeReq) begin
        storeData <= storeWord;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bit test on a data word
  wire selectedBit;
  // Index 0 selects the most significant bit, as instructions count it
  assign selectedBit = dataBusIn[4'hF - bitSel];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tcFlag <= 1'b0;
    end else if (bitTest) begin
      tcFlag <= selectedBit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Branch evaluation
  wire condMet;
  wire [15:0] nextTarget;

  assign condMet =
    (branchCond == dad_pkg::DAD_BC_ALWAYS) ? 1'b1 :
    (branchCond == dad_pkg::DAD_BC_EQ)     ? (acc == 32'h0000_0000) :
    (branchCond == dad_pkg::DAD_BC_NE)     ? (acc != 32'h0000_0000) :
    (branchCond == dad_pkg::DAD_BC_LT)     ? acc[31] :
    (branchCond == dad_pkg::DAD_BC_GT)     ? (!acc[31] && (acc != 32'h0000_0000)) :
    (branchCond == dad_pkg::DAD_BC_BIT)    ? tcFlag :
    1'b0;
  // Accumulator branches use the low half as address
  assign nextTarget = branchAcc ? acc[15:0] : branchImm;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      brTaken  <= 1'b0;
      brTarget <= 16'h0000;
    end else begin
      brTaken <= branchReq && condMet;
      if (branchReq) begin
        brTarget <= nextTarget;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign dataBusOut       = storeData;
  assign dataBusWr        = storeStrobe;
  assign accOut           = acc;
  assign productOut       = product_reg;
  assign mult_operand_reg = opReg;
  assign branchTaken      = brTaken;
  assign branchTarget     = brTarget;
  assign testBit          = tcFlag;
  assign carry            = carryFlag;
  assign overflow         = ovFlag;
  assign normDone         = isNorm;

endmodule
`default_nettype wire

//--- dv/dad_arith_datapath_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dad_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [3:0]  aluOp,
  input wire logic        selProduct,
  input wire logic [1:0]  prodMode,
  input wire logic        loadOpReg,
  input wire logic        storeHigh,
  input wire logic        storeLow,
  input wire logic [2:0]  storeShift,
  input wire logic        bitTest,
  input wire logic [3:0]  bitSel,
  input wire logic        branchReq,
  input wire logic [15:0] dataBusIn,
  input wire logic [15:0] dataBusOut,
  input wire logic        dataBusWr,
  input wire logic [31:0] accOut,
  input wire logic [31:0] productOut,
  input wire logic [15:0] mult_operand_reg,
  input wire logic        branchTaken,
  input wire logic        testBit
);
  ////////////////////////////////////////////////////////////////
  // Helper values; $past only ever sees plain signals
  wire logic        storeReq = storeHigh | storeLow;
  wire logic [31:0] stVal    = accOut << storeShift;
  wire logic [15:0] stHi     = stVal[31:16];
  wire logic [15:0] stLo     = stVal[15:0];
  wire logic        selBit   = dataBusIn[4'hf - bitSel];  // Index 0 is the MSB

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Store steps: request taken, then strobe with the shifted half
  sequence sStore;
    storeReq;
  endsequence
  sequence sLowOnly;
    storeLow && !storeHigh;
  endsequence

  ////////////////////////////////////////////////////////////////
  AST_WR_PULSE: assert property (sStore |=> dataBusWr)
    else $error("store strobe missing");
  AST_WR_ONLY: assert property (dataBusWr |-> $past(storeReq))
    else $error("store strobe without request");
  AST_ST_HIGH: assert property (storeHigh |=> dataBusOut == $past(stHi))
    else $error("high half store value wrong");
  AST_ST_LOW: assert property (sLowOnly |=> dataBusOut == $past(stLo))
    else $error("low half store value wrong");
  AST_ST_KEEP: assert property (sStore ##0 aluOp == dad_pkg::DAD_OP_NOP |=> $stable(accOut))
    else $error("store changed accumulator");
  AST_OPREG: assert property (loadOpReg |=> mult_operand_reg == $past(dataBusIn))
    else $error("held operand not loaded");
  AST_ADD_PR: assert property (aluOp == dad_pkg::DAD_OP_ADD && selProduct &&
    prodMode == dad_pkg::DAD_PM_NONE |=> accOut == $past(accOut) + $past(productOut))
    else $error("product add result wrong");
  AST_BIT: assert property (bitTest |=> testBit == $past(selBit))
    else $error("bit test result wrong");
  AST_BR_ONE: assert property (branchTaken |-> $past(branchReq))
    else $error("branch taken without request");
endmodule

bind dad_arith_datapath dad_chk dad_chk_inst (.clk_sys, .rst_n, .aluOp, .selProduct,
  .prodMode, .loadOpReg, .storeHigh, .storeLow, .storeShift, .bitTest, .bitSel,
  .branchReq, .dataBusIn, .dataBusOut, .dataBusWr, .accOut, .productOut,
  .mult_operand_reg, .branchTaken, .testBit);
`default_nettype wire

//--- dv/dad_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module dad_bus_model (
  input  wire logic        clk_sys,
  input  wire logic        drive,    // A read is in progress
  input  wire logic [15:0] dataVal,
  input  wire logic [15:0] progVal,
  output logic      [15:0] dataBus,
  output logic      [15:0] progBus
);
  logic [15:0] lastData = 16'h0000;
  logic [15:0] lastProg = 16'h0000;
  // Released buses show the inverse of the last value, so stale reads show up
  assign dataBus = drive ? dataVal : ~lastData;
  assign progBus = drive ? progVal : ~lastProg;
  always_ff @(posedge clk_sys) begin
    if (drive) begin
      lastData <= dataVal;
      lastProg <= progVal;
    end
  end
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_sys, rst_n, selProduct, sextMode, mulSigned, loadOpReg, mulStart;
  logic        mulFromProg, storeHigh, storeLow, branchReq, branchAcc, bitTest, drive;
  logic        dataBusWr, branchTaken, testBit, normDone, carry, overflow;
  logic [3:0]  aluOp, bitSel;
  logic [4:0]  shiftAmt;
  logic [1:0]  prodMode;
  logic [2:0]  storeShift, branchCond;
  logic [15:0] branchImm, dataVal, progVal, dataBusIn, progBusIn, dataBusOut;
  logic [15:0] mult_operand_reg, branchTarget;
  logic [31:0] accOut, productOut, expAcc, p;
  int          fails, n_checks, cycles, k;
  typedef struct { logic [15:0] d; logic [4:0] sh; logic sx; logic [31:0] q; } dad_row_t;
  // Scaler rows: operand, shift, sign mode, accumulator after a load
  dad_row_t    rows [6] = '{'{16'h8001, 5'h00, 1'h1, 32'hFFFF_8001},
    '{16'h8001, 5'h10, 1'h1, 32'h8001_0000}, '{16'h8001, 5'h04, 1'h0, 32'h0008_0010},
    '{16'h8000, 5'h0F, 1'h1, 32'hC000_0000}, '{16'h7FFF, 5'h01, 1'h1, 32'h0000_FFFE},
    '{16'hF00F, 5'h10, 1'h0, 32'hF00F_0000}};

  dad_arith_datapath dad_arith_datapath_inst (.clk_sys, .rst_n, .aluOp, .selProduct,
    .shiftAmt, .sign_ext_mode_bit(sextMode), .prodMode, .mulSigned, .loadOpReg,
    .mulStart, .mulFromProg, .storeHigh, .storeLow, .storeShift, .branchCond,
    .branchReq, .branchAcc, .branchImm, .bitTest, .bitSel, .dataBusIn, .progBusIn,
    .dataBusOut, .dataBusWr, .accOut, .productOut, .mult_operand_reg, .branchTaken,
    .branchTarget, .testBit, .carry, .overflow, .normDone);
  dad_bus_model dad_bus_model_inst (.clk_sys, .drive, .dataVal, .progVal,
    .dataBus(dataBusIn), .progBus(progBusIn));

  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Hang guard; the run needs about 130 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // All decoder controls idle, buses released
  task automatic clr();
    {aluOp, selProduct, shiftAmt, sextMode, prodMode, mulSigned, loadOpReg} <= '0;
    {mulStart, mulFromProg, storeHigh, storeLow, storeShift, branchCond} <= '0;
    {branchReq, branchAcc, branchImm, bitTest, bitSel, drive, dataVal, progVal} <= '0;
  endtask
  // Edge that takes the request; results settle before returning
  task automatic go();
    @(posedge clk_sys);
    clr();
    #1;
  endtask
  task automatic alu(input logic [3:0] op, input logic [15:0] d, input logic [4:0] sh,
                     input logic sx, input logic sel, input logic [1:0] pm);
    @(posedge clk_sys);
    {aluOp, dataVal, drive, shiftAmt, sextMode, selProduct, prodMode} <= {op, d, 1'h1, sh, sx, sel, pm};
    go();
  endtask
  task automatic mul(input logic s, input logic fp, input logic [15:0] d, input logic [15:0] pv);
    @(posedge clk_sys);
    {mulStart, mulSigned, mulFromProg, dataVal, progVal, drive} <= {1'h1, s, fp, d, pv, 1'h1};
    go();
  endtask
  task automatic bt(input logic [3:0] sel, input logic [15:0] d, input logic q);
    @(posedge clk_sys);
    {bitTest, bitSel, dataVal, drive} <= {1'h1, sel, d, 1'h1};
    go();
    check(testBit, q);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    clr();
    rst_n = 1'h0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
    #1;
    check(accOut, 32'h0000_0000);
    check(normDone, 1'h1);
    foreach (rows[i]) begin
      alu(dad_pkg::DAD_OP_LOAD, rows[i].d, rows[i].sh, rows[i].sx, 1'h0, 2'h0);
      check(accOut, rows[i].q);
    end
    // Operations chain on one accumulator; code 0 must leave it alone
    alu(dad_pkg::DAD_OP_LOAD, 16'h1234, 5'h10, 1'h0, 1'h0, 2'h0);
    alu(dad_pkg::DAD_OP_OR, 16'h5678, 5'h00, 1'h0, 1'h0, 2'h0);
    expAcc = 32'h1234_5678;
    for (k = 0; k <= 5; k++) begin
      alu(4'(k), 16'hF0F0, 5'h00, 1'h0, 1'h0, 2'h0);
      case (k)
        1: expAcc = expAcc + 32'h0000_F0F0;
        2: expAcc = expAcc - 32'h0000_F0F0;
        3: expAcc = expAcc & 32'h0000_F0F0;
        4: expAcc = expAcc | 32'h0000_F0F0;
        5: expAcc = expAcc ^ 32'h0000_F0F0;
        default: ;
      endcase
      check(accOut, expAcc);
    end
    // Non-zero accumulator so a swapped half or a missed shift shows
    alu(dad_pkg::DAD_OP_LOAD, 16'hA5C3, 5'h08, 1'h0, 1'h0, 2'h0);
    expAcc = 32'h00A5_C300;
    check(accOut, expAcc);
    // Back-to-back stores: high half then low half, accumulator kept
    @(posedge clk_sys);
    {storeHigh, storeShift} <= {1'h1, 3'h3};
    @(posedge clk_sys);
    {storeHigh, storeLow, storeShift} <= {1'h0, 1'h1, 3'h7};
    #1;
    p = expAcc << 3;
    check(dataBusOut, p[31:16]);
    go();
    p = expAcc << 7;
    check(dataBusOut, p[15:0]);
    check(dataBusWr, 1'h1);
    check(accOut, expAcc);
    @(posedge clk_sys);
    #1;
    check(dataBusWr, 1'h0);
    // Multiplier: held operand, signed and unsigned, factor from program bus
    @(posedge clk_sys);
    {loadOpReg, dataVal, drive} <= {1'h1, 16'hFFFE, 1'h1};
    go();
    check(mult_operand_reg, 16'hFFFE);
    mul(1'h1, 1'h0, 16'h0003, 16'h0000);
    check(productOut, 32'hFFFF_FFFA);
    mul(1'h0, 1'h0, 16'h0003, 16'h0000);
    check(productOut, 32'h0002_FFFA);
    mul(1'h1, 1'h1, 16'h7777, 16'h0002);
    check(productOut, 32'hFFFF_FFFC);
    p = 32'hFFFF_FFFC;
    for (k = 0; k < 4; k++) begin
      alu(dad_pkg::DAD_OP_LOAD, 16'h0000, 5'h00, 1'h0, 1'h0, 2'h0);
      alu(dad_pkg::DAD_OP_ADD, 16'h0000, 5'h00, 1'h0, 1'h1, 2'(k));
      case (k)
        0: expAcc = p;
        1: expAcc = p << dad_pkg::PM_LEFT1_AMT;
        2: expAcc = p << dad_pkg::PM_LEFT4_AMT;
        default: expAcc = $signed(p) >>> dad_pkg::PM_RIGHT6_AMT;
      endcase
      check(accOut, expAcc);
    end
    // Multiply-accumulate adds the product path like a plain add
    alu(dad_pkg::DAD_OP_MAC, 16'h0000, 5'h00, 1'h0, 1'h1, 2'h0);
    expAcc = expAcc + 32'hFFFF_FFFC;
    check(accOut, expAcc);
    check(carry, 1'h1);
    check(overflow, 1'h0);
    bt(4'h0, 16'h7FFF, 1'h0);
    bt(4'hF, 16'h0001, 1'h1);
    bt(4'h1, 16'h4000, 1'h1);
    // Every condition on a negative accumulator with the test flag set
    for (k = 0; k < 7; k++) begin
      @(posedge clk_sys);
      {branchReq, branchCond, branchAcc, branchImm} <= {1'h1, 3'(k), k[0], 16'hBEE0};
      go();
      p = 32'h0000_002D;
      check(branchTaken, p[k]);
      check(branchTarget, k[0] ? expAcc[15:0] : 16'hBEE0);
    end
    alu(dad_pkg::DAD_OP_LOAD, 16'h1000, 5'h00, 1'h0, 1'h0, 2'h0);
    for (k = 0; normDone !== 1'h1 && k < 40; k++)
      alu(dad_pkg::DAD_OP_NORM, 16'h0000, 5'h00, 1'h0, 1'h0, 2'h0);
    check(k, 18);
    check(accOut, 32'h4000_0000);
    // Reset in mid-run clears the datapath registers
    @(posedge clk_sys);
    rst_n <= 1'h0;
    @(posedge clk_sys);
    rst_n <= 1'h1;
    #1;
    check(accOut, 32'h0000_0000);
    check(productOut, 32'h0000_0000);
    end_sim();
  end
endmodule
`default_nettype wire
